// >>> hdl/kwi_map.svh
// kwi_map.svh - register offsets, field positions and reset values of the
// keypad wake interrupt block.
// assumes: included by its bare name from the package and the design files.
`ifndef KWI_MAP_SVH
`define KWI_MAP_SVH

// bus and pin widths
`define KWI_AW        8
`define KWI_DW        32
`define KWI_NPIN      5

// register byte offsets
`define KWI_OFS_SC    8'h00
`define KWI_OFS_EN    8'h04

// status and control field positions
`define KWI_SC_MODE   0
`define KWI_SC_MASK   1
`define KWI_SC_ACK    2
`define KWI_SC_PEND   3
`define KWI_SC_TOP    7
`define KWI_SC_UNUSED 4

// pin enable field
`define KWI_EN_MSB    4
`define KWI_EN_LSB    0

// reset values
`define KWI_MASK_RST  1'b0
`define KWI_MODE_RST  1'b0
`define KWI_EN_RST    5'h00
`define KWI_PREV_RST  1'b1
`define KWI_ZERO32    32'h0000_0000
`define KWI_VEC_RST   16'h0000

// vector address pair, high byte first
`define KWI_VECTOR    16'hFFE4

`endif

// >>> hdl/kwi_pkg.sv
// kwi_pkg - types shared by the keypad wake interrupt design files.
// assumes: kwi_map.svh is on the include path.
`include "kwi_map.svh"

package kwi_pkg;

    // request latch states, gray along idle -> pending -> held
    typedef enum logic [1:0] {
        KWI_ST_IDLE = 2'h0,
        KWI_ST_PEND = 2'h1,
        KWI_ST_HELD = 2'h3
    } kwi_state_t;

    // apb request from the master
    typedef struct packed {
        logic                psel;
        logic                penable;
        logic                pwrite;
        logic [`KWI_AW-1:0]  paddr;
        logic [`KWI_DW-1:0]  pwdata;
    } kwi_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic                pready;
        logic                pslverr;
        logic [`KWI_DW-1:0]  prdata;
    } kwi_apb_rsp_t;

    // pad controls for the five keypad pins
    typedef struct packed {
        logic [`KWI_NPIN-1:0] pull_en;
        logic [`KWI_NPIN-1:0] out_en;
        logic [`KWI_NPIN-1:0] rd_ok;
    } kwi_pad_t;

endpackage : kwi_pkg

// >>> hdl/kwi_pins.sv
// kwi_pins - per-pin pad control and level detection for the keypad pins.
// assumes: pin levels are synchronous to clock; enables come from a register.
`timescale 1ns/1ps
`default_nettype none
`include "kwi_map.svh"

module kwi_pins (
    // pins and port setup
    input  wire logic [`KWI_NPIN-1:0] keypad_pin,
    input  wire logic [`KWI_NPIN-1:0] port_a_direction,
    input  wire logic [`KWI_NPIN-1:0] pin_latch_enables,
    // pad controls
    output kwi_pkg::kwi_pad_t         pad,
    // level summary of enabled pins
    output logic                      any_low
);
    import kwi_pkg::*;

    logic [`KWI_NPIN-1:0] low_vec;

    genvar g;
    generate
        for (g = 0; g < `KWI_NPIN; g = g + 1) begin : g_pin
            // enabling a pin switches its pull-up on
            assign pad.pull_en[g] = pin_latch_enables[g];
            // an enabled pin is forced to input whatever its direction bit
            assign pad.out_en[g]  = port_a_direction[g] & ~pin_latch_enables[g];
            // software still needs the direction bit low to read the pin
            assign pad.rd_ok[g]   = ~port_a_direction[g];
            // disabled pins never count as low
            assign low_vec[g]     = pin_latch_enables[g] & ~keypad_pin[g];
        end
    endgenerate

    assign any_low = |low_vec;

endmodule : kwi_pins
`default_nettype wire

// >>> hdl/kwi_core.sv
// kwi_core - keypad wake interrupt unit: five-pin request latch with
// edge or edge-and-level sensitivity, mask, acknowledge and wake.
// assumes: apb master on clock, pins synchronous, vector_fetch is a
// one-cycle pulse from the cpu when it fetches the keypad vector.
//
// Functional notes
// - each pin has an enable bit that also turns on its pull-up
// - request latches when an enabled pin falls after all were high
// - edge-only: no latch while another enabled pin is already low
// - edge-and-level: request stays while any enabled pin is low
// - edge-and-level: clears only after acknowledge and all pins high, any order
// - vector fetch pulse acknowledges and clears the pending request
// - writing one to acknowledge clears the request; bit reads zero
// - acknowledge does not block later edges; new fall latches again
// - unmasked request makes the cpu take the vector pair FFE4/FFE5
// - edge-only: acknowledge clears the request at once, any pin levels
// - reset clears request and sensitivity even with a pin low
// - pending flag reads one while pending, whatever the mask
// - enabled pin forced to input; reads still need direction zero
// - mask set withholds cpu requests; reset clears mask
// - logic stays active in wait and stop; unmasked request wakes cpu
// - in break with clear-enable set, software may clear the flag
// - in break with clear-enable zero, acknowledge writes leave the flag; mask and sensitivity bits still load
// - upper four bits of status and control read as zero
// - sensitivity bit: one edges plus levels, zero edges only
// - reset clears all pin enables
`timescale 1ns/1ps
`default_nettype none
`include "kwi_map.svh"

module kwi_core (
    // clock, reset, enable
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 clk_en,
    // apb slave
    input  wire kwi_pkg::kwi_apb_req_t apb_req,
    output kwi_pkg::kwi_apb_rsp_t     apb_rsp,
    // keypad pins and port direction
    input  wire logic [`KWI_NPIN-1:0] keypad_pin,
    input  wire logic [`KWI_NPIN-1:0] port_a_direction,
    output kwi_pkg::kwi_pad_t         pad,
    // cpu side
    input  wire logic                 vector_fetch,
    input  wire logic                 wait_mode,
    input  wire logic                 stop_mode,
    output logic                      irq_req,
    output logic                      cpu_wake,
    output logic [15:0]               vector_addr,
    // break support
    input  wire logic                 break_state,
    input  wire logic                 break_clear_enable
);
    import kwi_pkg::*;

    // registers
    kwi_state_t           st_q;
    kwi_state_t           st_d;
    logic                 request_mask_q;
    logic                 trigger_sensitivity_q;
    logic [`KWI_NPIN-1:0] pin_en_q;
    logic                 prev_high_q;
    logic [`KWI_DW-1:0]   prdata_q;
    logic [15:0]          vec_q;

    // bus decode
    logic                 acc;
    logic                 sel_sc;
    logic                 sel_en;
    logic                 hit;
    logic                 wr_take;
    logic                 wr_sc;
    logic                 wr_en;
    logic                 rd_load;
    logic [`KWI_DW-1:0]   rd_mux;
    logic [`KWI_DW-1:0]   sc_word;
    logic [`KWI_DW-1:0]   en_word;

    // request logic
    logic                 any_low;
    logic                 fall_evt;
    logic                 ack_wr;
    logic                 ack_wr_ok;
    logic                 ack;
    logic                 pending_flag;

    kwi_pins u_pins (
        .keypad_pin        (keypad_pin),
        .port_a_direction  (port_a_direction),
        .pin_latch_enables (pin_en_q),
        .pad               (pad),
        .any_low           (any_low)
    );

    // address decode; unmapped addresses answer with an error
    assign acc     = apb_req.psel & apb_req.penable;
    assign sel_sc  = (apb_req.paddr == `KWI_OFS_SC);
    assign sel_en  = (apb_req.paddr == `KWI_OFS_EN);
    assign hit     = sel_sc | sel_en;
    // a frozen block stretches the access instead of dropping it
    assign wr_take = acc & apb_req.pwrite & clk_en;
    assign wr_sc   = wr_take & sel_sc;
    assign wr_en   = wr_take & sel_en;
    assign rd_load = apb_req.psel & ~apb_req.pwrite & clk_en;

    assign apb_rsp.pready  = clk_en;
    assign apb_rsp.pslverr = acc & ~hit;
    assign apb_rsp.prdata  = prdata_q;

    // status word: ack bit and bits 7..4 read as zero
    always_comb begin
        sc_word = `KWI_ZERO32;
        sc_word[`KWI_SC_PEND] = pending_flag;
        sc_word[`KWI_SC_MASK] = request_mask_q;
        sc_word[`KWI_SC_MODE] = trigger_sensitivity_q;
    end

    always_comb begin
        en_word = `KWI_ZERO32;
        en_word[`KWI_EN_MSB:`KWI_EN_LSB] = pin_en_q;
    end

    assign rd_mux = sel_sc ? sc_word : (sel_en ? en_word : `KWI_ZERO32);

    // edge seen only if every enabled pin was high the cycle before
    assign fall_evt = prev_high_q & any_low;

    // in break, acknowledge writes only count with clear-enable set
    assign ack_wr    = wr_sc & apb_req.pwdata[`KWI_SC_ACK];
    assign ack_wr_ok = ack_wr & (~break_state | break_clear_enable);
    assign ack       = vector_fetch | ack_wr_ok;

    // request latch
    always_comb begin
        st_d = st_q;
        case (st_q)
            KWI_ST_IDLE: begin
                // level mode also raises a request on a pin held low
                if (fall_evt | (trigger_sensitivity_q & any_low)) begin
                    st_d = KWI_ST_PEND;
                end
            end
            KWI_ST_PEND: begin
                if (ack & ~fall_evt) begin
                    // edge-only clears at once; level waits for pins
                    if (trigger_sensitivity_q & any_low) begin
                        st_d = KWI_ST_HELD;
                    end else begin
                        st_d = KWI_ST_IDLE;
                    end
                end
            end
            KWI_ST_HELD: begin
                if (fall_evt) begin
                    st_d = KWI_ST_PEND;
                end else if (~any_low | ~trigger_sensitivity_q) begin
                    st_d = KWI_ST_IDLE;
                end
            end
            default: begin
                st_d = KWI_ST_IDLE;
            end
        endcase
    end

    // pending holds through both held and pending states
    assign pending_flag = (st_q != KWI_ST_IDLE);

    // mask gates the cpu request but not the flag
    assign irq_req  = pending_flag & ~request_mask_q;
    // no clock gating of this block in wait or stop
    assign cpu_wake = irq_req & (wait_mode | stop_mode);
    assign vector_addr = vec_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q <= KWI_ST_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prev_high_q <= `KWI_PREV_RST;
        end else if (clk_en) begin
            prev_high_q <= ~any_low;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            request_mask_q        <= `KWI_MASK_RST;
            trigger_sensitivity_q <= `KWI_MODE_RST;
        end else if (wr_sc) begin
            request_mask_q        <= apb_req.pwdata[`KWI_SC_MASK];
            trigger_sensitivity_q <= apb_req.pwdata[`KWI_SC_MODE];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pin_en_q <= `KWI_EN_RST;
        end else if (wr_en) begin
            pin_en_q <= apb_req.pwdata[`KWI_EN_MSB:`KWI_EN_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_q <= `KWI_ZERO32;
        end else if (rd_load) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            vec_q <= `KWI_VEC_RST;
        end else if (clk_en) begin
            vec_q <= `KWI_VECTOR;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    logic rd_sc_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_sc_q <= 1'b0;
        end else begin
            rd_sc_q <= rd_load & sel_sc;
        end
    end

    AST_PULLUP_FOLLOWS_WRITE: assert property (
        wr_en |=> pad.pull_en == $past(apb_req.pwdata[`KWI_EN_MSB:`KWI_EN_LSB])
    ) else $error("pull-ups do not follow enable write");

    AST_FALL_LATCHES: assert property (
        clk_en && st_q == KWI_ST_IDLE && fall_evt |=> pending_flag
    ) else $error("falling pin did not latch a request");

    AST_EDGE_NO_LATCH_LOW: assert property (
        clk_en && st_q == KWI_ST_IDLE && !prev_high_q && !trigger_sensitivity_q
        |=> !pending_flag
    ) else $error("edge mode latched while a pin was already low");

    AST_LEVEL_HOLDS: assert property (
        clk_en && trigger_sensitivity_q && any_low && pending_flag
        && !wr_sc |=> pending_flag
    ) else $error("level request dropped while a pin is low");

    AST_EDGE_ACK_CLEARS: assert property (
        clk_en && ack && !fall_evt && !trigger_sensitivity_q
        && st_q == KWI_ST_PEND |=> !pending_flag
    ) else $error("edge mode acknowledge did not clear");

    AST_ACK_READS_ZERO: assert property (
        rd_sc_q |-> prdata_q[`KWI_SC_ACK] == 1'b0 && prdata_q[`KWI_SC_TOP:`KWI_SC_UNUSED] == 4'h0
    ) else $error("ack or unused bits read nonzero");

    AST_MASK_BLOCKS: assert property (
        request_mask_q |-> !irq_req && !cpu_wake
    ) else $error("masked request reached the cpu");

    AST_UNMASKED_REQ: assert property (
        pending_flag && !request_mask_q |-> irq_req && vector_addr == `KWI_VECTOR
    ) else $error("unmasked request not raised with vector");

    AST_BREAK_PROTECT: assert property (
        clk_en && break_state && !break_clear_enable && ack_wr && !vector_fetch
        && st_q == KWI_ST_PEND |=> pending_flag
    ) else $error("acknowledge in break cleared a protected flag");

    AST_RESET_CLEARS: assert property (
        @(posedge clock) disable iff (1'b0)
        !nrst |=> st_q == KWI_ST_IDLE && !trigger_sensitivity_q && pin_en_q == `KWI_EN_RST
    ) else $error("reset left request, sensitivity or enables set");

    AST_LEVEL_ACK_WAITS: assert property (
        clk_en && trigger_sensitivity_q && any_low && pending_flag && ack
        |=> pending_flag
    ) else $error("level acknowledge cleared while a pin is low");

    AST_LEVEL_RELEASE: assert property (
        clk_en && st_q == KWI_ST_HELD && !any_low |=> !pending_flag
    ) else $error("held request stayed after all pins went high");

    AST_FETCH_CLEARS: assert property (
        clk_en && vector_fetch && !fall_evt && (!any_low || !trigger_sensitivity_q)
        && pending_flag |=> !pending_flag
    ) else $error("vector fetch did not clear the request");

    AST_FALL_ALWAYS_LATCHES: assert property (
        clk_en && fall_evt |=> pending_flag
    ) else $error("falling pin after acknowledge was lost");

    AST_FLAG_READS: assert property (
        rd_sc_q |-> prdata_q[`KWI_SC_PEND] == $past(pending_flag)
        && prdata_q[`KWI_SC_MASK] == $past(request_mask_q)
    ) else $error("pending flag read back wrong");

    AST_ENABLED_IS_INPUT: assert property (
        (pad.out_en & pad.pull_en) == '0
    ) else $error("enabled keypad pin still driven");

    AST_WAKE: assert property (
        irq_req && (wait_mode || stop_mode) |-> cpu_wake
    ) else $error("unmasked request did not wake the cpu");

    AST_BREAK_CLEAR: assert property (
        clk_en && break_state && break_clear_enable && ack_wr && !fall_evt
        && !trigger_sensitivity_q && st_q == KWI_ST_PEND |=> !pending_flag
    ) else $error("acknowledge in break with clear enable did not clear");

    AST_LEVEL_IDLE_LATCH: assert property (
        clk_en && trigger_sensitivity_q && st_q == KWI_ST_IDLE && any_low
        |=> pending_flag
    ) else $error("level mode ignored a low pin");

    // a low clock enable must leave every register of the latch untouched
    AST_FREEZE_HOLDS: assert property (
        !clk_en |=> $stable(st_q) && $stable(request_mask_q) && $stable(trigger_sensitivity_q)
        && $stable(pin_en_q) && $stable(prdata_q)
    ) else $error("state moved while the clock enable was low");

    COV_EDGE_ACK: cover property (
        st_q == KWI_ST_PEND && ack && !trigger_sensitivity_q ##1 st_q == KWI_ST_IDLE
    );
    COV_LEVEL_HELD: cover property (
        st_q == KWI_ST_HELD ##1 st_q == KWI_ST_IDLE
    );
    COV_BREAK_BLOCK: cover property (
        break_state && !break_clear_enable && ack_wr && pending_flag
    );
    COV_WAKE: cover property (cpu_wake);

endmodule : kwi_core
`default_nettype wire

// >>> dv/kwi_keys.sv
// kwi_keys - behavioural keypad switches on the five keypad pins.
// assumes: press comes from the bench, pull-ups from the block's pad controls.
`timescale 1ns/1ps
`default_nettype none
`include "kwi_map.svh"

module kwi_keys (
    // clock for the open-pin pattern
    input  wire logic                 clock,
    // switch closures and pull-ups
    input  wire logic [`KWI_NPIN-1:0] press,
    input  wire logic [`KWI_NPIN-1:0] pull_en,
    // pin levels
    output logic      [`KWI_NPIN-1:0] keypad_pin
);
    logic [`KWI_NPIN-1:0] float_q = 5'h0A;

    // an open pin without pull-up has no level; a changing pattern keeps it honest
    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    // a closed switch pulls low, an open one is high through the pull-up and follows float_q without it
    assign keypad_pin = ~press & (pull_en | float_q);
endmodule : kwi_keys
`default_nettype wire

// >>> dv/keypad_wake_interrupt_test.sv
// keypad_wake_interrupt_test - register and pin level test of kwi_core.
// assumes: kwi_keys models the switches; apb master lives in the tasks here.
`timescale 1ns/1ps
`default_nettype none
`include "kwi_map.svh"

module keypad_wake_interrupt_test;
    import kwi_pkg::*;
    logic         clock, nrst, clk_en, vector_fetch, wait_mode, stop_mode;
    logic         break_state, break_clear_enable, irq_req, cpu_wake, perr;
    logic [4:0]   keypad_pin, port_a_direction, press;
    logic [15:0]  vector_addr;
    logic [31:0]  rdata;
    kwi_apb_req_t apb_req;
    kwi_apb_rsp_t apb_rsp;
    kwi_pad_t     pad;
    int           num_errors, compares;

    kwi_core i_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .keypad_pin(keypad_pin), .port_a_direction(port_a_direction), .pad(pad),
        .vector_fetch(vector_fetch), .wait_mode(wait_mode), .stop_mode(stop_mode), .irq_req(irq_req),
        .cpu_wake(cpu_wake), .vector_addr(vector_addr), .break_state(break_state),
        .break_clear_enable(break_clear_enable));
    kwi_keys i_keys (.clock(clock), .press(press), .pull_en(pad.pull_en), .keypad_pin(keypad_pin));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic stop_test();
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic sig(input string what, input logic seen, input logic exp);
        chk(what, {31'h0, seen}, {31'h0, exp});
    endtask : sig

    // one apb transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= d;
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rdata = apb_rsp.prdata;
        perr  = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rdata, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic keys(input logic [4:0] p);
        @(posedge clock);
        press <= p;
        tick(2);
    endtask : keys

    task automatic fetch();
        @(posedge clock);
        vector_fetch <= 1'b1;
        @(posedge clock);
        vector_fetch <= 1'b0;
        tick(1);
    endtask : fetch

    // a hang ends the run through the same closing report
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        stop_test();
    end

    initial begin
        num_errors = 0;
        compares = 0;
        {nrst, vector_fetch, wait_mode, stop_mode, break_state, break_clear_enable} = 6'h00;
        clk_en = 1'b1;
        port_a_direction = 5'h1F;
        press = 5'h00;
        apb_req = '0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rd("sc after reset", `KWI_OFS_SC, 32'h0);
        rd("en after reset", `KWI_OFS_EN, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped data", rdata, 32'h0);
        sig("unmapped err", perr, 1'b1);
        @(posedge clock);
        clk_en <= 1'b0;
        tick(1);
        sig("pready frozen", apb_rsp.pready, 1'b0);
        @(posedge clock);
        clk_en <= 1'b1;
        // mask first so pull-ups settle without a request
        wr(`KWI_OFS_SC, 32'hFFFF_FFF2);
        rd("sc upper bits", `KWI_OFS_SC, 32'h2);
        wr(`KWI_OFS_EN, 32'h3);
        #1;
        chk("pull two", {27'h0, pad.pull_en}, 32'h3);
        chk("drive two", {27'h0, pad.out_en}, 32'h1C);
        chk("read ok", {27'h0, pad.rd_ok}, 32'h0);
        wr(`KWI_OFS_EN, 32'hFFFF_FFFF);
        rd("en all", `KWI_OFS_EN, 32'h1F);
        chk("pull all", {27'h0, pad.pull_en}, 32'h1F);
        wr(`KWI_OFS_SC, 32'h6);
        wr(`KWI_OFS_SC, 32'h0);
        wait_mode <= 1'b1;
        keys(5'h01);
        rd("edge pend", `KWI_OFS_SC, 32'h8);
        sig("irq", irq_req, 1'b1);
        chk("vector", {16'h0, vector_addr}, 32'hFFE4);
        sig("wake wait", cpu_wake, 1'b1);
        wr(`KWI_OFS_SC, 32'h4);
        rd("ack pin low", `KWI_OFS_SC, 32'h0);
        keys(5'h03);
        rd("edge other low", `KWI_OFS_SC, 32'h0);
        keys(5'h00);
        keys(5'h04);
        rd("edge after ack", `KWI_OFS_SC, 32'h8);
        wr(`KWI_OFS_SC, 32'h2);
        rd("masked pend", `KWI_OFS_SC, 32'hA);
        sig("masked irq", irq_req, 1'b0);
        sig("masked wake", cpu_wake, 1'b0);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        wr(`KWI_OFS_SC, 32'h0);
        #1;
        sig("wake stop", cpu_wake, 1'b1);
        fetch();
        rd("fetch clear", `KWI_OFS_SC, 32'h0);
        sig("wake gone", cpu_wake, 1'b0);
        keys(5'h00);
        wr(`KWI_OFS_SC, 32'h1);
        keys(5'h08);
        rd("level pend", `KWI_OFS_SC, 32'h9);
        wr(`KWI_OFS_SC, 32'h5);
        rd("level ack low", `KWI_OFS_SC, 32'h9);
        keys(5'h00);
        rd("level release", `KWI_OFS_SC, 32'h1);
        keys(5'h08);
        keys(5'h00);
        rd("level no ack", `KWI_OFS_SC, 32'h9);
        wr(`KWI_OFS_SC, 32'h5);
        rd("level ack last", `KWI_OFS_SC, 32'h1);
        wr(`KWI_OFS_SC, 32'h0);
        keys(5'h10);
        keys(5'h00);
        @(posedge clock);
        break_state <= 1'b1;
        wr(`KWI_OFS_SC, 32'h4);
        rd("break kept", `KWI_OFS_SC, 32'h8);
        break_clear_enable <= 1'b1;
        wr(`KWI_OFS_SC, 32'h4);
        rd("break clear", `KWI_OFS_SC, 32'h0);
        break_state <= 1'b0;
        tick(2);
        rd("after break", `KWI_OFS_SC, 32'h0);
        wr(`KWI_OFS_SC, 32'h1);
        keys(5'h01);
        @(posedge clock);
        nrst <= 1'b0;
        tick(2);
        sig("irq in reset", irq_req, 1'b0);
        @(posedge clock);
        nrst <= 1'b1;
        rd("sc reset pin low", `KWI_OFS_SC, 32'h0);
        rd("en reset again", `KWI_OFS_EN, 32'h0);
        stop_test();
    end
endmodule : keypad_wake_interrupt_test
`default_nettype wire
